// ---- logic/motion_event_click_detect.sv ----
// Motion generator two and tap source logic behind an Avalon-MM slave.
//
// Summary of operation
// - Seven-bit motion threshold in threshold low bits, reset zero.
// - Threshold top bit: 0 clears duration counter, 1 decrements it.
// - Eight-bit duration, reset zero, minimum persistence before interrupt.
// - At 400 Hz each duration count is 2.5 ms.
// - At 100 Hz each duration count is 10 ms.
// - Latched and event satisfied: duration counter holds its value.
// - Tap latch bit keeps tap flags until tap source is read.
// - Six tap enables, single and double per axis, reset zero.
// - Per axis: 00 none, 01 single, 10 double, 11 either.
// - Tap source active flag is one when enabled taps occurred.
// - Six tap event flags, one per tap kind and axis.
// - Reading motion source clears it and its interrupt output.
// - Combine bit: 0 ORs enabled events, 1 ANDs them.
// - High above threshold, low below threshold, each only if enabled.
//
// Our own choice: the Avalon-MM register port.
`timescale 1ns/1ps
module motion_event_click_detect
    import motion_event_pkg::*;
#(
    parameter int FAST_DIV = STEP_FAST_CYC,
    parameter int SLOW_DIV = STEP_SLOW_CYC
) (
    input  wire logic        ref_clk,
    input  wire logic        sys_rst,
    input  wire logic [9:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    input  wire logic [3:0]  byteenable,
    output logic [31:0]      readdata,
    output logic             waitrequest,
    input  wire logic [7:0]  accel_x,
    input  wire logic [7:0]  accel_y,
    input  wire logic [7:0]  accel_z,
    input  wire logic        tap_single_x,
    input  wire logic        tap_double_x,
    input  wire logic        tap_single_y,
    input  wire logic        tap_double_y,
    input  wire logic        tap_single_z,
    input  wire logic        tap_double_z,
    output logic             sample_tick,
    output logic             motion2_int,
    output logic             tap_int,
    output logic             irq
);
    import motion_event_pkg::*;

    // ------------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------------
    logic [7:0]       m2_cfg_q;
    logic [7:0]       m2_ths_q;
    logic [7:0]       m2_dur_q;
    logic [6:0]       tap_cfg_q;
    logic [0:0]       ctrl_q;
    logic [IRQ_W-1:0] irq_stat_q;
    logic [IRQ_W-1:0] irq_mask_q;
    logic [31:0]      readdata_q;
    bus_state_t       bus_state_q;

    // ------------------------------------------------------------------
    // Internal nets
    // ------------------------------------------------------------------
    logic [7:0]       idx;
    logic             done;
    logic             wr_en;
    logic             rd_done;
    logic [31:0]      rd_mux;
    logic [DIV_W-1:0] div_q;
    logic [DIV_W-1:0] div_last;
    logic [THS_W-1:0] ths;
    logic [EV_W-1:0]  raw_ev;
    logic [EV_W-1:0]  en_ev;
    logic [EV_W-1:0]  m2_enable;
    logic             m2_active;
    logic             m2_fire;
    logic             m2_hold;
    logic [EV_W-1:0]  m2_flags;
    logic             m2_ia;
    logic [EV_W-1:0]  tap_raw;
    logic [EV_W-1:0]  tap_rep;
    logic [EV_W-1:0]  tap_flags;
    logic             tap_ia;
    logic             tap_any;
    logic [IRQ_W-1:0] irq_set;

    // ------------------------------------------------------------------
    // Avalon-MM slave handshake
    // ------------------------------------------------------------------

    // Every access takes exactly one wait state, so the read mux has a
    // full cycle before the data must stand at the completing edge.
    assign idx         = address[9:2];
    assign done        = (bus_state_q == BUS_ACK);
    assign waitrequest = (read || write) && !done;
    assign wr_en       = write && done && byteenable[0];
    assign rd_done     = read && done;
    assign readdata    = readdata_q;

    // Handshake sequencer: idle, then one acknowledge cycle.
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            bus_state_q <= BUS_IDLE;
        else
        begin
            case (bus_state_q)
                BUS_IDLE: if (read || write) bus_state_q <= BUS_ACK;
                BUS_ACK:  bus_state_q <= BUS_IDLE;
                default:  bus_state_q <= BUS_IDLE;
            endcase
        end
    end

    // Read mux; unmapped addresses and reserved bits read as zero.
    always_comb
    begin
        rd_mux = 32'h0000_0000;
        case (idx)
            IDX_M2_CFG:   rd_mux[7:0] = m2_cfg_q;
            IDX_M2_SRC:   rd_mux[7:0] = {1'b0, m2_ia, m2_flags};
            IDX_M2_THS:   rd_mux[7:0] = m2_ths_q;
            IDX_M2_DUR:   rd_mux[7:0] = m2_dur_q;
            IDX_TAP_CFG:  rd_mux[7:0] = {1'b0, tap_cfg_q};
            IDX_TAP_SRC:  rd_mux[7:0] = {1'b0, tap_ia, tap_flags};
            IDX_CTRL:     rd_mux[0:0] = ctrl_q;
            IDX_IRQ_STAT: rd_mux[IRQ_W-1:0] = irq_stat_q;
            IDX_IRQ_MASK: rd_mux[IRQ_W-1:0] = irq_mask_q;
            default:      rd_mux = 32'h0000_0000;
        endcase
    end

    // Read data is captured as the request is first seen and stands
    // through the completing edge.
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            readdata_q <= 32'h0000_0000;
        else if (read && !done)
            readdata_q <= rd_mux;
    end

    // ------------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------------

    // Motion generator settings; only the low byte lane is used.
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            m2_cfg_q <= CFG_RST;
            m2_ths_q <= THS_RST;
            m2_dur_q <= DUR_RST;
        end
        else if (wr_en)
        begin
            if (idx == IDX_M2_CFG) m2_cfg_q <= writedata[7:0];
            if (idx == IDX_M2_THS) m2_ths_q <= writedata[7:0];
            if (idx == IDX_M2_DUR) m2_dur_q <= writedata[7:0];
        end
    end

    // Tap configuration and the sample rate select.
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            tap_cfg_q <= TAP_RST;
            ctrl_q    <= CTRL_RST;
        end
        else if (wr_en)
        begin
            if (idx == IDX_TAP_CFG) tap_cfg_q <= writedata[6:0];
            if (idx == IDX_CTRL)
                ctrl_q <= writedata[CTRL_RATE_BIT +: 1];
        end
    end

    // ------------------------------------------------------------------
    // Sample rate divider
    // ------------------------------------------------------------------

    // The duration step is one sample period, so the rate select alone
    // sets the step length; changing the rate restarts no count.
    assign div_last = ctrl_q[0] ? DIV_W'(FAST_DIV - 1)
                                : DIV_W'(SLOW_DIV - 1);

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            div_q       <= '0;
            sample_tick <= 1'b0;
        end
        else
        begin
            sample_tick <= (div_q >= div_last);
            div_q       <= (div_q >= div_last) ? '0 : div_q + 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Motion generator two
    // ------------------------------------------------------------------

    // Per-axis comparisons, ordered Z high down to X low.
    assign ths    = m2_ths_q[THS_W-1:0];
    assign raw_ev = {magnitude(accel_z) > ths, magnitude(accel_z) < ths,
                     magnitude(accel_y) > ths, magnitude(accel_y) < ths,
                     magnitude(accel_x) > ths,
                     magnitude(accel_x) < ths};
    assign m2_enable = m2_cfg_q[EV_W-1:0];
    assign en_ev     = raw_ev & m2_enable;

    // With AND, every enabled event must hold and at least one must be
    // enabled, otherwise an empty set would fire on every sample.
    assign m2_active = m2_cfg_q[CFG_COMB_BIT]
                     ? ((en_ev == m2_enable) && (m2_enable != '0))
                     : (|en_ev);

    // A satisfied latched event freezes the duration count.
    assign m2_hold = m2_cfg_q[CFG_LATCH_BIT] && m2_ia;

    motion_duration_counter #(
        .W (8)
    ) u_duration (
        .ref_clk      (ref_clk),
        .sys_rst      (sys_rst),
        .step         (sample_tick),
        .active       (m2_active),
        .hold         (m2_hold),
        .release_mode (m2_ths_q[THS_MODE_BIT]),
        .duration     (m2_dur_q),
        .expired      (m2_fire)
    );

    // Unlatched, the source follows each sample; latched, it keeps
    // the events until the host reads it.
    event_source_reg #(
        .W (EV_W)
    ) u_m2_source (
        .ref_clk  (ref_clk),
        .sys_rst  (sys_rst),
        .update   (sample_tick),
        .events   (m2_fire ? en_ev : '0),
        .latch    (m2_cfg_q[CFG_LATCH_BIT]),
        .rd_clr   (rd_done && (idx == IDX_M2_SRC)),
        .flags_q  (m2_flags),
        .active_q (m2_ia)
    );

    assign motion2_int = m2_ia;

    // ------------------------------------------------------------------
    // Tap source
    // ------------------------------------------------------------------

    // Each pair of enables picks single, double or both per axis.
    assign tap_raw = {tap_double_z, tap_single_z, tap_double_y,
                      tap_single_y, tap_double_x, tap_single_x};
    assign tap_rep = tap_raw & tap_cfg_q[EV_W-1:0];
    assign tap_any = |tap_rep;

    // Unlatched flags show the most recent reported tap until the next
    // one or a read; latched flags accumulate until read.
    event_source_reg #(
        .W (EV_W)
    ) u_tap_source (
        .ref_clk  (ref_clk),
        .sys_rst  (sys_rst),
        .update   (tap_any),
        .events   (tap_rep),
        .latch    (tap_cfg_q[CFG_LATCH_BIT]),
        .rd_clr   (rd_done && (idx == IDX_TAP_SRC)),
        .flags_q  (tap_flags),
        .active_q (tap_ia)
    );

    assign tap_int = tap_ia;

    // ------------------------------------------------------------------
    // Interrupt status and mask
    // ------------------------------------------------------------------

    assign irq_set[IRQ_M2_BIT]  = sample_tick && m2_fire;
    assign irq_set[IRQ_TAP_BIT] = tap_any;

    // Sticky status, cleared by writing one; a new event wins over the
    // clear in the same cycle so none is lost.
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            irq_stat_q <= '0;
        else if (wr_en && (idx == IDX_IRQ_STAT))
            irq_stat_q <= (irq_stat_q & ~writedata[IRQ_W-1:0]) | irq_set;
        else
            irq_stat_q <= irq_stat_q | irq_set;
    end

    // Mask register, a one lets the status bit reach the output.
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            irq_mask_q <= MASK_RST;
        else if (wr_en && (idx == IDX_IRQ_MASK))
            irq_mask_q <= writedata[IRQ_W-1:0];
    end

    // Level interrupt, registered to keep the pin glitch free.
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            irq <= 1'b0;
        else
            irq <= |(irq_stat_q & irq_mask_q);
    end

endmodule // motion_event_click_detect

// ---- logic/motion_event_pkg.sv ----
// Shared constants, register map and helpers for the motion and tap block.
package motion_event_pkg;

    // ------------------------------------------------------------------
    // Clock and sample timing
    // ------------------------------------------------------------------
    localparam int    CLK_PERIOD_NS = 40;
    localparam longint STEP_FAST_NS = 2_500_000;   // Step at 400 Hz rate.
    localparam longint STEP_SLOW_NS = 10_000_000;  // Step at 100 Hz rate.
    localparam int    STEP_FAST_CYC = int'(STEP_FAST_NS / CLK_PERIOD_NS);
    localparam int    STEP_SLOW_CYC = int'(STEP_SLOW_NS / CLK_PERIOD_NS);
    localparam int    DIV_W         = 18;

    // ------------------------------------------------------------------
    // Register indices; the byte address is four times the index
    // ------------------------------------------------------------------
    localparam logic [7:0] IDX_M2_CFG   = 8'h34;
    localparam logic [7:0] IDX_M2_SRC   = 8'h35;
    localparam logic [7:0] IDX_M2_THS   = 8'h36;
    localparam logic [7:0] IDX_M2_DUR   = 8'h37;
    localparam logic [7:0] IDX_TAP_CFG  = 8'h38;
    localparam logic [7:0] IDX_TAP_SRC  = 8'h39;
    localparam logic [7:0] IDX_CTRL     = 8'h40;
    localparam logic [7:0] IDX_IRQ_STAT = 8'h41;
    localparam logic [7:0] IDX_IRQ_MASK = 8'h42;

    // ------------------------------------------------------------------
    // Field positions and widths
    // ------------------------------------------------------------------
    localparam int THS_W          = 7;
    localparam int THS_MODE_BIT   = 7;
    localparam int CFG_COMB_BIT   = 7;
    localparam int CFG_LATCH_BIT  = 6;
    localparam int EV_W           = 6;
    localparam int SRC_ACTIVE_BIT = 6;
    localparam int CTRL_RATE_BIT  = 0;
    localparam int IRQ_W          = 2;
    localparam int IRQ_M2_BIT     = 0;
    localparam int IRQ_TAP_BIT    = 1;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [7:0]       THS_RST  = 8'h00;
    localparam logic [7:0]       DUR_RST  = 8'h00;
    localparam logic [7:0]       CFG_RST  = 8'h00;
    localparam logic [6:0]       TAP_RST  = 7'h00;
    localparam logic [0:0]       CTRL_RST = 1'h0;
    localparam logic [IRQ_W-1:0] MASK_RST = 2'h0;

    // Bus handshake states, Gray ordered.
    typedef enum logic [0:0] {
        BUS_IDLE = 1'b0,
        BUS_ACK  = 1'b1
    } bus_state_t;

    // Magnitude of a signed sample, saturated to the threshold width.
    function automatic logic [THS_W-1:0] magnitude(input logic [7:0] s);
        logic [7:0] n;
        n = s[7] ? 8'(~s + 8'h01) : s;
        return n[7] ? {THS_W{1'b1}} : n[THS_W-1:0];
    endfunction

endpackage

// ---- logic/motion_duration_counter.sv ----
// Duration counter of the second motion generator.
`timescale 1ns/1ps
module motion_duration_counter #(
    parameter int W = 8
) (
    input  wire logic         ref_clk,
    input  wire logic         sys_rst,
    input  wire logic         step,
    input  wire logic         active,
    input  wire logic         hold,
    input  wire logic         release_mode,
    input  wire logic [W-1:0] duration,
    output logic              expired
);
    logic [W-1:0] count_q;

    // The event fires once it has persisted for the programmed steps.
    assign expired = active && (count_q >= duration);

    // Count on each sample step; hold while a latched event waits.
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            count_q <= '0;
        else if (step && !hold)
        begin
            if (active)
            begin
                if (count_q < duration)
                    count_q <= count_q + 1'b1;
            end
            else if (release_mode)
            begin
                if (count_q != '0)
                    count_q <= count_q - 1'b1;
            end
            else
                count_q <= '0;
        end
    end
endmodule // motion_duration_counter

// ---- logic/event_source_reg.sv ----
// Event source flags, optionally latched until read.
`timescale 1ns/1ps
module event_source_reg #(
    parameter int W = 6
) (
    input  wire logic         ref_clk,
    input  wire logic         sys_rst,
    input  wire logic         update,
    input  wire logic [W-1:0] events,
    input  wire logic         latch,
    input  wire logic         rd_clr,
    output logic [W-1:0]      flags_q,
    output logic              active_q
);
    logic [W-1:0] flags_d;

    // A new event on the clearing read survives: set wins over clear.
    always_comb
    begin
        flags_d = flags_q;
        if (latch)
            flags_d = (rd_clr ? '0 : flags_q) | (update ? events : '0);
        else if (update)
            flags_d = events;
        else if (rd_clr)
            flags_d = '0;
    end

    // Flags and the summary flag move together.
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            flags_q  <= '0;
            active_q <= 1'b0;
        end
        else
        begin
            flags_q  <= flags_d;
            active_q <= |flags_d;
        end
    end
endmodule // event_source_reg

// ---- verif/motion_event_click_detect_monitor.sv ----
// Concurrent checks on the motion and tap block ports.
`timescale 1ns/1ps
module motion_event_click_detect_monitor
    import motion_event_pkg::*;
#(
    parameter int FAST_DIV = 8,
    parameter int SLOW_DIV = 20
) (
    input wire logic        ref_clk,
    input wire logic        sys_rst,
    input wire logic [9:0]  address,
    input wire logic        read,
    input wire logic        write,
    input wire logic [31:0] readdata,
    input wire logic        waitrequest,
    input wire logic        tap_single_x,
    input wire logic        tap_double_x,
    input wire logic        tap_single_y,
    input wire logic        tap_double_y,
    input wire logic        tap_single_z,
    input wire logic        tap_double_z,
    input wire logic        sample_tick,
    input wire logic        motion2_int,
    input wire logic        tap_int,
    input wire logic        irq
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    // ------
    // Helper logic
    // ------
    logic [31:0] gap_q;
    logic        seen_q;
    logic        rd_done;
    logic        any_tap;

    assign rd_done = read & ~waitrequest;
    assign any_tap = tap_single_x | tap_double_x | tap_single_y |
                     tap_double_y | tap_single_z | tap_double_z;

    // Cycles since the last tick; a rate write may shorten one period.
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst || sample_tick)
            gap_q <= 32'h0;
        else
            gap_q <= gap_q + 32'h1;
        if (sys_rst || (write && address[9:2] == IDX_CTRL))
            seen_q <= 1'b0;
        else if (sample_tick)
            seen_q <= 1'b1;
    end

    // ------
    // Assertions
    // ------
    AST_WAIT_ONE:
        assert property ((read || write) && waitrequest |=> !waitrequest)
        else $error("bus request not answered after one wait");
    AST_RD_HIGH:
        assert property (rd_done |-> readdata[31:8] == 24'h0)
        else $error("upper read data bits not zero");
    AST_TAP_CAUSE:
        assert property ($rose(tap_int) |-> $past(any_tap))
        else $error("tap interrupt rose without a tap pulse");
    AST_M2_CAUSE:
        assert property ($rose(motion2_int) |-> $past(sample_tick))
        else $error("motion interrupt rose off a sample tick");
    AST_TICK_PULSE:
        assert property (sample_tick |=> !sample_tick)
        else $error("sample tick longer than one cycle");
    AST_TICK_GAP:
        assert property (sample_tick && seen_q |->
            gap_q >= FAST_DIV - 1 && gap_q <= SLOW_DIV - 1)
        else $error("sample tick spacing out of range");
    AST_TAPINT_FALL:
        assert property ($fell(tap_int) |->
            $past(rd_done && address[9:2] == IDX_TAP_SRC))
        else $error("tap interrupt dropped without a source read");
    AST_M2INT_FALL:
        assert property ($fell(motion2_int) |-> $past(sample_tick) ||
            $past(rd_done && address[9:2] == IDX_M2_SRC))
        else $error("motion interrupt dropped without tick or read");
    AST_RESET_OUTS:
        assert property ($fell(sys_rst) |-> !irq && !tap_int && !motion2_int)
        else $error("outputs not cleared by reset");

    COV_TAP: cover property ($rose(tap_int));
    COV_M2:  cover property ($rose(motion2_int));
    COV_IRQ: cover property ($rose(irq));
endmodule // motion_event_click_detect_monitor

// ---- verif/motion_host_model.sv ----
// Avalon-MM host model issuing register reads and writes.
`timescale 1ns/1ps
module motion_host_model (
    input  wire logic        ref_clk,
    input  wire logic        waitrequest,
    input  wire logic [31:0] readdata,
    output logic [9:0]       address,
    output logic             read,
    output logic             write,
    output logic [31:0]      writedata,
    output logic [3:0]       byteenable
);
    // Bus idles with no request at time zero.
    initial
    begin
        address = 10'h0;
        read = 1'b0;
        write = 1'b0;
        writedata = 32'h0;
        byteenable = 4'h0;
    end

    // One access; the stall is sampled at each rising edge only.
    task automatic xfer(input logic is_wr, input logic [7:0] idx,
                        input logic [7:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge ref_clk);
        address    <= {idx, 2'b00};
        writedata  <= {24'h0, d};
        byteenable <= 4'h1;
        read       <= ~is_wr;
        write      <= is_wr;
        do
            @(posedge ref_clk);
        while (waitrequest !== 1'b0 && ++n < 100);
        q = readdata;
        read       <= 1'b0;
        write      <= 1'b0;
        address    <= ~address;
        writedata  <= ~writedata;
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [31:0] unused;
        xfer(1'b1, idx, d, unused);
    endtask

    task automatic rd(input logic [7:0] idx, output logic [31:0] q);
        xfer(1'b0, idx, 8'h00, q);
    endtask
endmodule // motion_host_model

// ---- verif/motion_event_click_detect_tb_top.sv ----
// Self-checking bench for the motion and tap register block.
`timescale 1ns/1ps
module motion_event_click_detect_tb_top;
    import motion_event_pkg::*;
    localparam int FAST = 8;
    localparam int SLOW = 20;
    logic        ref_clk, sys_rst, read, write, waitrequest;
    logic        sample_tick, motion2_int, tap_int, irq;
    logic [9:0]  address;
    logic [31:0] writedata, readdata, q;
    logic [3:0]  byteenable;
    logic [7:0]  accel_x, accel_y, accel_z, v, en;
    logic [5:0]  tp;
    logic [7:0]  regs [10] = '{8'h34, 8'h35, 8'h36, 8'h37, 8'h38,
                               8'h39, 8'h40, 8'h41, 8'h42, 8'h10};
    int          n_errors, tests_run, seed, gap, n;

    motion_event_click_detect #(.FAST_DIV(FAST), .SLOW_DIV(SLOW))
    u_motion_event_click_detect (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .address(address),
        .read(read), .write(write), .writedata(writedata),
        .byteenable(byteenable), .readdata(readdata),
        .waitrequest(waitrequest), .accel_x(accel_x), .accel_y(accel_y),
        .accel_z(accel_z), .tap_single_x(tp[0]), .tap_double_x(tp[1]),
        .tap_single_y(tp[2]), .tap_double_y(tp[3]), .tap_single_z(tp[4]),
        .tap_double_z(tp[5]), .sample_tick(sample_tick),
        .motion2_int(motion2_int), .tap_int(tap_int), .irq(irq));

    motion_host_model u_host (
        .ref_clk(ref_clk), .waitrequest(waitrequest), .readdata(readdata),
        .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(byteenable));

    // ------
    // Clock, watchdog and shared tasks
    // ------
    initial
    begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    // Run should need a few hundred cycles; this cuts a hang short.
    initial
    begin
        #(40 * 20000);
        n_errors++;
        summarize();
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic summarize();
        $display("checks %0d errors %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic tap(input int k);
        @(posedge ref_clk);
        tp <= 6'(1 << k);
        @(posedge ref_clk);
        tp <= 6'h0;
    endtask

    // Waits for the motion interrupt and reports how long it took.
    task automatic wait_m2(output int c);
        c = 0;
        while (motion2_int !== 1'b1 && c < 400)
        begin
            @(negedge ref_clk);
            c++;
        end
        chk(motion2_int, 1'b1);
    endtask

    task automatic tick_gap(output int g);
        repeat (2)
        begin
            g = 0;
            do
                @(negedge ref_clk);
            while (sample_tick !== 1'b1 && ++g < 200);
        end
        g = 0;
        do
        begin
            @(negedge ref_clk);
            g++;
        end
        while (sample_tick !== 1'b1 && g < 200);
    endtask

    // ------
    // Main sequence
    // ------
    initial
    begin
        seed = 3;
        sys_rst = 1'b1;
        tp = 6'h0;
        accel_x = 8'h00;
        accel_y = 8'h00;
        accel_z = 8'h00;
        repeat (4) @(posedge ref_clk);
        sys_rst <= 1'b0;
        accel_z <= 8'($random(seed));
        foreach (regs[i])
        begin
            u_host.rd(regs[i], q);
            chk(q, 32'h0);
        end
        repeat (4)
        begin
            v = 8'($random(seed));
            u_host.wr(IDX_M2_THS, v);
            u_host.rd(IDX_M2_THS, q);
            chk(q, {24'h0, v});
            u_host.wr(IDX_M2_DUR, ~v);
            u_host.rd(IDX_M2_DUR, q);
            chk(q, {24'h0, ~v});
        end
        // Every enable pattern per axis against every tap kind.
        for (int k = 0; k < 6; k++)
            for (int m = 0; m < 4; m++)
            begin
                en = 8'(m * 21);
                u_host.wr(IDX_TAP_CFG, en);
                tap(k);
                u_host.rd(IDX_TAP_SRC, q);
                chk(q, en[k] ? 32'h40 | (32'h1 << k) : 32'h0);
            end
        u_host.wr(IDX_TAP_CFG, 8'hff);
        u_host.rd(IDX_TAP_CFG, q);
        chk(q, 32'h7f);
        tap(0);
        tap(5);
        u_host.rd(IDX_TAP_SRC, q);
        chk(q, 32'h61);
        u_host.rd(IDX_TAP_SRC, q);
        chk(q, 32'h0);
        @(negedge ref_clk);
        chk(tap_int, 1'b0);
        u_host.wr(IDX_TAP_CFG, 8'h3f);
        tap(0);
        tap(5);
        u_host.rd(IDX_TAP_SRC, q);
        chk(q, 32'h60);
        // Interrupt raised, acknowledged, then masked.
        u_host.wr(IDX_IRQ_MASK, 8'h02);
        tap(1);
        repeat (3) @(negedge ref_clk);
        chk(irq, 1'b1);
        u_host.rd(IDX_IRQ_STAT, q);
        chk(q, 32'h2);
        u_host.rd(IDX_TAP_SRC, q);
        u_host.wr(IDX_IRQ_STAT, 8'h02);
        repeat (3) @(negedge ref_clk);
        chk(irq, 1'b0);
        u_host.wr(IDX_IRQ_MASK, 8'h00);
        tap(1);
        repeat (3) @(negedge ref_clk);
        chk(irq, 1'b0);
        for (int r = 0; r < 2; r++)
        begin
            u_host.wr(IDX_CTRL, 8'(r));
            tick_gap(gap);
            chk(gap, r ? FAST : SLOW);
        end
        // Latched high event with a three-step duration.
        u_host.wr(IDX_M2_THS, 8'h90);
        u_host.wr(IDX_M2_DUR, 8'h03);
        u_host.wr(IDX_M2_CFG, 8'h42);
        accel_x <= 8'h30;
        wait_m2(n);
        chk(n >= 3 * FAST, 1'b1);
        @(posedge ref_clk);
        accel_x <= 8'h00;
        repeat (3 * FAST) @(posedge ref_clk);
        u_host.rd(IDX_M2_SRC, q);
        chk(q, 32'h42);
        @(negedge ref_clk);
        chk(motion2_int, 1'b0);
        // AND of two low events: one held off, then both present.
        u_host.wr(IDX_M2_DUR, 8'h00);
        u_host.wr(IDX_M2_CFG, 8'h85);
        accel_x <= 8'hfd;
        accel_y <= 8'h40;
        repeat (3 * FAST) @(negedge ref_clk);
        chk(motion2_int, 1'b0);
        @(posedge ref_clk);
        accel_y <= 8'hf8;
        wait_m2(n);
        u_host.rd(IDX_M2_SRC, q);
        chk(q, 32'h45);
        summarize();
    end
endmodule // motion_event_click_detect_tb_top

bind motion_event_click_detect motion_event_click_detect_monitor #(
    .FAST_DIV(FAST_DIV), .SLOW_DIV(SLOW_DIV)) u_mon (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .address(address),
    .read(read), .write(write), .readdata(readdata),
    .waitrequest(waitrequest), .tap_single_x(tap_single_x),
    .tap_double_x(tap_double_x), .tap_single_y(tap_single_y),
    .tap_double_y(tap_double_y), .tap_single_z(tap_single_z),
    .tap_double_z(tap_double_z), .sample_tick(sample_tick),
    .motion2_int(motion2_int), .tap_int(tap_int), .irq(irq));
